// ---- include/dfm_pkg.sv ----
// ==========================================================================
// Shared constants for the drive digital I/O function map.
// ==========================================================================
package dfm_pkg;

    // ======================================================================
    // Object dictionary indexes and sub-indexes.
    // ======================================================================
    localparam logic [15:0] IDX_INPUT4 = 16'h3024;
    localparam logic [15:0] IDX_OUTFUNC = 16'h3030;
    localparam logic [7:0] SUB_ENTRY_COUNT = 8'h00;
    localparam logic [7:0] SUB_IN4_FUNC = 8'h01;
    localparam logic [7:0] SUB_IN4_STATE = 8'h02;
    localparam logic [7:0] SUB_IN4_POL = 8'h03;
    localparam logic [7:0] SUB_IN4_LAST = 8'h05;
    localparam logic [7:0] SUB_OF_ENABLE = 8'h01;
    localparam logic [7:0] SUB_OF_STATE = 8'h02;
    localparam logic [7:0] SUB_OF_POL = 8'h03;
    localparam logic [7:0] SUB_OF_RAW = 8'h04;
    localparam logic [7:0] SUB_OF_LAST = 8'h06;

    // ======================================================================
    // Fixed entry values and reset values.
    // ======================================================================
    localparam logic [15:0] IN4_ENTRY_COUNT = 16'h0005;
    localparam logic [15:0] OF_ENTRY_COUNT = 16'h0006;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [31:0] RST_CODE = 32'h0000_0000;

    // ======================================================================
    // Abort codes returned to the master.
    // ======================================================================
    localparam logic [31:0] ABORT_NO_SUBINDEX = 32'h0609_0011;
    localparam logic [31:0] ABORT_NO_OBJECT = 32'h0602_0000;
    localparam logic [31:0] ABORT_READ_ONLY = 32'h0601_0002;

    // ======================================================================
    // Input function codes and output function codes.
    // ======================================================================
    typedef enum logic [3:0] {
        dfm_in_none = 4'h0,
        dfm_in_run = 4'h1,
        dfm_in_stop = 4'h2,
        dfm_in_urgent_halt = 4'h3,
        dfm_in_reset = 4'h4,
        dfm_in_jog_clockwise = 4'h5,
        dfm_in_jog_counter_clockwise = 4'h6,
        dfm_in_preset_speed_one = 4'h7,
        dfm_in_preset_speed_two = 4'h8,
        dfm_in_preset_speed_three = 4'h9,
        dfm_in_preset_speed_four = 4'ha,
        dfm_in_speed_or_torque_select = 4'hb,
        dfm_in_direction = 4'hc
    } dfm_in_func_t;

    typedef enum logic [2:0] {
        dfm_out_none = 3'h0,
        dfm_out_drive_ok = 3'h1,
        dfm_out_warning = 3'h2,
        dfm_out_goal_attained = 3'h3,
        dfm_out_brake = 3'h4,
        dfm_out_ready = 3'h5,
        dfm_out_motion = 3'h6,
        dfm_out_full_turn_sense = 3'h7
    } dfm_out_func_t;

    // Bit positions of the functions in every mask word.
    localparam int FB_DRIVE_OK = 0;
    localparam int FB_WARNING = 1;
    localparam int FB_GOAL = 2;
    localparam int FB_BRAKE = 3;
    localparam int FB_READY = 4;
    localparam int FB_MOTION = 5;
    localparam int FB_FULL_TURN = 6;
    localparam int NUM_FUNCS = 7;

    // Default output assignment and polarity.
    localparam logic [2:0] DEF_OUT1_FUNC = 3'h1;
    localparam logic [2:0] DEF_OUT2_FUNC = 3'h2;
    localparam logic [2:0] DEF_OUT3_FUNC = 3'h5;
    localparam logic [2:0] DEF_OUT4_FUNC = 3'h4;
    localparam logic [15:0] DEF_OUT_POLARITY = 16'h0000;
    localparam logic [3:0] DEF_IN4_FUNC = 4'h0;
    localparam logic DEF_IN4_POLARITY = 1'b0;

    // ======================================================================
    // Timing.
    // ======================================================================
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

endpackage : dfm_pkg

// ---- include/dfm_in_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Qualified input level and its edges, from the pin qualifier to the map.
// ==========================================================================
interface dfm_in_if;
    logic level;
    logic rise_evt;
    logic fall_evt;

    modport src (output level, output rise_evt, output fall_evt);
    modport dst (input level, input rise_evt, input fall_evt);
endinterface : dfm_in_if
`default_nettype wire

// ---- src/dfm_pin_qual.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Three-stage pin synchroniser with agreement check and edge events.
// ==========================================================================
module dfm_pin_qual (
    // Clock, reset and enable.
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    // Asynchronous pin.
    input wire logic pin_async,
    // Qualified result.
    dfm_in_if.src q
);
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic level;
    logic rise;
    logic fall;
    logic next_level;
    logic next_rise;
    logic next_fall;

    // A change counts only once the second and third stages agree.
    always_comb begin
        next_level = level;
        if (sync_b == sync_c) begin
            next_level = sync_c;
        end
        next_rise = next_level & ~level;
        next_fall = ~next_level & level;
    end

    // Registers all stages; the first stage feeds only the second.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
            level <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else if (ce) begin
            sync_a <= pin_async;
            sync_b <= sync_a;
            sync_c <= sync_b;
            level <= next_level;
            rise <= next_rise;
            fall <= next_fall;
        end
    end

    assign q.level = level;
    assign q.rise_evt = rise;
    assign q.fall_evt = fall;
endmodule : dfm_pin_qual
`default_nettype wire

// ---- src/dfm_motion_qual.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Motion detection: speed above threshold for the threshold time.
// ==========================================================================
module dfm_motion_qual #(
    parameter int MS_CYCLES = dfm_pkg::MS_CYCLES
) (
    // Clock, reset and enable.
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    // Speed, threshold and qualification time in milliseconds.
    input wire logic [31:0] velocity,
    input wire logic [31:0] velocity_threshold,
    input wire logic [15:0] threshold_time_ms,
    // Qualified motion level.
    output logic moving
);
    logic [31:0] pre_cnt;
    logic [15:0] ms_cnt;
    logic next_moving;
    logic [31:0] next_pre_cnt;
    logic [15:0] next_ms_cnt;
    logic above;

    // Counts whole milliseconds while the speed stays above the threshold.
    always_comb begin
        above = velocity > velocity_threshold;
        next_pre_cnt = pre_cnt;
        next_ms_cnt = ms_cnt;
        next_moving = 1'b0;
        if (above) begin
            if (ms_cnt >= threshold_time_ms) begin
                next_moving = 1'b1;
            end else if (pre_cnt >= 32'(MS_CYCLES - 1)) begin
                next_pre_cnt = 32'h0000_0000;
                next_ms_cnt = ms_cnt + 16'h0001;
            end else begin
                next_pre_cnt = pre_cnt + 32'h0000_0001;
            end
        end else begin
            next_pre_cnt = 32'h0000_0000;
            next_ms_cnt = 16'h0000;
        end
    end

    // Registers the timer state.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pre_cnt <= 32'h0000_0000;
            ms_cnt <= 16'h0000;
            moving <= 1'b0;
        end else if (ce) begin
            pre_cnt <= next_pre_cnt;
            ms_cnt <= next_ms_cnt;
            moving <= next_moving;
        end
    end
endmodule : dfm_motion_qual
`default_nettype wire

// ---- src/dfm_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Drive digital I/O function map: input 4 object and output function object.
// ==========================================================================

// Notes on behaviour
// - Input 4 configuration object is read-only; writes are refused.
// - Input function code 0 is none; 1 to 12 pick run through direction.
// - Input state reads 1 for high level active, 0 for low inactive.
// - Input polarity reads 0 for positive edge, 1 for negative edge.
// - A nonexistent sub-index is refused with the sub-index abort code.
// - Mask bit n stands for output function n+1; bits 7 to 15 unused.
// - Output function object has six read-only 16-bit sub-entries.
// - State mask bit reads 0 when its function is active, 1 otherwise.
// - Polarity mask bit reads 0 for positive, 1 for negative polarity.
// - Raw levels entry carries outputs one to four in bits 0 to 3.
// - Drive-ok function is 1 with no alarm, 0 while an alarm is present.
// - Warning function is 1 while at least one warning is present.
// - Goal-attained function is reserved and stays inactive.
// - Brake function follows the holding brake state.
// - Ready function shows the drive may enter the running state.
// - Motion function is 1 once speed exceeds threshold for the timer.
// - Default outputs: drive-ok, warning, ready, brake on outputs 1 to 4.
module dfm_top #(
    parameter logic [3:0] IN4_FUNCTION = dfm_pkg::DEF_IN4_FUNC,
    parameter logic IN4_POLARITY = dfm_pkg::DEF_IN4_POLARITY,
    parameter logic [2:0] OUT1_FUNC = dfm_pkg::DEF_OUT1_FUNC,
    parameter logic [2:0] OUT2_FUNC = dfm_pkg::DEF_OUT2_FUNC,
    parameter logic [2:0] OUT3_FUNC = dfm_pkg::DEF_OUT3_FUNC,
    parameter logic [2:0] OUT4_FUNC = dfm_pkg::DEF_OUT4_FUNC,
    parameter logic [15:0] OUT_POLARITY = dfm_pkg::DEF_OUT_POLARITY,
    parameter int MS_CYCLES = dfm_pkg::MS_CYCLES
) (
    // Clock, reset and clock enable.
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    // Object dictionary access from the protocol engine.
    input wire logic od_req,
    input wire logic od_write,
    input wire logic [15:0] od_index,
    input wire logic [7:0] od_subindex,
    output logic od_ack,
    output logic od_abort,
    output logic [15:0] od_data,
    output logic [31:0] od_abort_code,
    // Drive status from logic on the same clock.
    input wire logic drive_alarm,
    input wire logic drive_warning,
    input wire logic brake_engaged,
    input wire logic drive_ready,
    input wire logic full_turn_sense,
    input wire logic [31:0] velocity,
    input wire logic [31:0] velocity_threshold,
    input wire logic [15:0] threshold_time_ms,
    // Digital input 4 pin, asynchronous.
    input wire logic din4_pin,
    // Digital outputs and input 4 edge event.
    output logic [3:0] dig_out,
    output logic in4_event
);

    // ======================================================================
    // Helper functions.
    // ======================================================================

    // Returns the mask bit of an output function code, zero for none.
    function automatic logic [15:0] func_bit(input logic [2:0] code);
        logic [15:0] m;
        m = 16'h0000;
        if (code != 3'h0) begin
            m[code - 3'h1] = 1'b1;
        end
        return m;
    endfunction : func_bit

    // Picks the level of an output from the function states and polarity.
    function automatic logic out_level(input logic [2:0] code,
                                       input logic [6:0] act,
                                       input logic [15:0] pol);
        logic lv;
        lv = 1'b0;
        if (code != 3'h0) begin
            lv = act[code - 3'h1] ^ pol[code - 3'h1];
        end
        return lv;
    endfunction : out_level

    // Builds a word with a 7-bit value in its low bits, upper bits zero.
    function automatic logic [15:0] low_word(input logic [6:0] v);
        return {9'h000, v};
    endfunction : low_word

    // ======================================================================
    // Constant masks fixed at build time.
    // ======================================================================

    // Enable mask marks every function that drives some output.
    localparam logic [15:0] ENABLE_MASK = func_bit(OUT1_FUNC) | func_bit(OUT2_FUNC) |
                                          func_bit(OUT3_FUNC) | func_bit(OUT4_FUNC);

    // Polarity mask keeps only the defined function bits.
    localparam logic [15:0] POL_MASK = OUT_POLARITY & 16'h007f;

    // Input function selection is fixed by the maker; codes above 12 read none.
    localparam logic [3:0] IN4_CODE = (IN4_FUNCTION > 4'hc) ? 4'h0 : IN4_FUNCTION;

    // ======================================================================
    // Sub-blocks.
    // ======================================================================
    dfm_in_if in4 ();
    logic moving;

    // Qualifies the asynchronous input pin.
    dfm_pin_qual u_in4 (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .pin_async(din4_pin),
        .q(in4)
    );

    // Qualifies motion against the threshold and its timer.
    dfm_motion_qual #(
        .MS_CYCLES(MS_CYCLES)
    ) u_motion (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .velocity(velocity),
        .velocity_threshold(velocity_threshold),
        .threshold_time_ms(threshold_time_ms),
        .moving(moving)
    );

    // ======================================================================
    // Function states and physical outputs.
    // ======================================================================
    logic [6:0] func_act;
    logic [6:0] next_func_act;
    logic [3:0] next_dig_out;
    logic next_in4_event;
    logic [2:0] out_code [4];

    assign out_code[0] = OUT1_FUNC;
    assign out_code[1] = OUT2_FUNC;
    assign out_code[2] = OUT3_FUNC;
    assign out_code[3] = OUT4_FUNC;

    // Gathers the state of each output function.
    always_comb begin
        next_func_act = 7'h00;
        next_func_act[dfm_pkg::FB_DRIVE_OK] = ~drive_alarm;
        next_func_act[dfm_pkg::FB_WARNING] = drive_warning;
        next_func_act[dfm_pkg::FB_GOAL] = 1'b0;
        next_func_act[dfm_pkg::FB_BRAKE] = brake_engaged;
        next_func_act[dfm_pkg::FB_READY] = drive_ready;
        next_func_act[dfm_pkg::FB_MOTION] = moving;
        next_func_act[dfm_pkg::FB_FULL_TURN] = full_turn_sense;
    end

    // Drives each output from its function, inverted by its polarity bit.
    always_comb begin
        next_dig_out = 4'h0;
        for (int k = 0; k < 4; k++) begin
            next_dig_out[k] = out_level(out_code[k], func_act, POL_MASK);
        end
    end

    // Signals the input edge that the polarity setting selects.
    always_comb begin
        next_in4_event = IN4_POLARITY ? in4.fall_evt : in4.rise_evt;
    end

    // Registers function states, outputs and the input event.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            func_act <= 7'h00;
            dig_out <= 4'h0;
            in4_event <= 1'b0;
        end else if (ce) begin
            func_act <= next_func_act;
            dig_out <= next_dig_out;
            in4_event <= next_in4_event;
        end
    end

    // ======================================================================
    // Object dictionary read path.
    // ======================================================================
    logic next_ack;
    logic next_abort;
    logic [15:0] next_data;
    logic [31:0] next_code;
    logic [15:0] state_mask;
    logic [15:0] raw_levels;

    // Inverted sense: a bit reads 0 while its function is active.
    assign state_mask = low_word(~func_act);

    // Raw levels mirror the physical outputs in bits 0 to 3.
    assign raw_levels = {12'h000, dig_out};

    // Decodes one access into data or an abort.
    always_comb begin
        next_ack = 1'b0;
        next_abort = 1'b0;
        next_data = dfm_pkg::RST_WORD;
        next_code = dfm_pkg::RST_CODE;
        if (od_req) begin
            next_ack = 1'b1;
            if (od_index == dfm_pkg::IDX_INPUT4) begin
                if (od_subindex > dfm_pkg::SUB_IN4_LAST) begin
                    next_abort = 1'b1;
                    next_code = dfm_pkg::ABORT_NO_SUBINDEX;
                end else if (od_write) begin
                    next_abort = 1'b1;
                    next_code = dfm_pkg::ABORT_READ_ONLY;
                end else begin
                    unique case (od_subindex)
                        dfm_pkg::SUB_ENTRY_COUNT: begin
                            next_data = dfm_pkg::IN4_ENTRY_COUNT;
                        end
                        dfm_pkg::SUB_IN4_FUNC: begin
                            next_data = {12'h000, IN4_CODE};
                        end
                        dfm_pkg::SUB_IN4_STATE: begin
                            next_data = {15'h0000, in4.level};
                        end
                        dfm_pkg::SUB_IN4_POL: begin
                            next_data = {15'h0000, IN4_POLARITY};
                        end
                        default: begin
                            next_data = dfm_pkg::RST_WORD;
                        end
                    endcase
                end
            end else if (od_index == dfm_pkg::IDX_OUTFUNC) begin
                if (od_subindex > dfm_pkg::SUB_OF_LAST) begin
                    next_abort = 1'b1;
                    next_code = dfm_pkg::ABORT_NO_SUBINDEX;
                end else if (od_write) begin
                    next_abort = 1'b1;
                    next_code = dfm_pkg::ABORT_READ_ONLY;
                end else begin
                    unique case (od_subindex)
                        dfm_pkg::SUB_ENTRY_COUNT: begin
                            next_data = dfm_pkg::OF_ENTRY_COUNT;
                        end
                        dfm_pkg::SUB_OF_ENABLE: begin
                            next_data = ENABLE_MASK;
                        end
                        dfm_pkg::SUB_OF_STATE: begin
                            next_data = state_mask;
                        end
                        dfm_pkg::SUB_OF_POL: begin
                            next_data = POL_MASK;
                        end
                        dfm_pkg::SUB_OF_RAW: begin
                            next_data = raw_levels;
                        end
                        default: begin
                            next_data = dfm_pkg::RST_WORD;
                        end
                    endcase
                end
            end else begin
                next_abort = 1'b1;
                next_code = dfm_pkg::ABORT_NO_OBJECT;
            end
        end
    end

    // Registers the answer; it stands for the one cycle of the acknowledge.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            od_ack <= 1'b0;
            od_abort <= 1'b0;
            od_data <= dfm_pkg::RST_WORD;
            od_abort_code <= dfm_pkg::RST_CODE;
        end else if (ce) begin
            od_ack <= next_ack;
            od_abort <= next_abort;
            od_data <= next_data;
            od_abort_code <= next_code;
        end
    end

endmodule : dfm_top
`default_nettype wire

// ---- tb/dfm_top_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Port checker for the function map.
// ==========================================================================
module dfm_top_sva #(
    parameter logic [15:0] OUT_POLARITY = 16'h0000
) (
    // Clock, reset and enable.
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    // Object dictionary access.
    input wire logic od_req,
    input wire logic od_write,
    input wire logic [15:0] od_index,
    input wire logic [7:0] od_subindex,
    input wire logic od_ack,
    input wire logic od_abort,
    input wire logic [15:0] od_data,
    input wire logic [31:0] od_abort_code,
    // Status and outputs.
    input wire logic drive_alarm,
    input wire logic brake_engaged,
    input wire logic [3:0] dig_out,
    input wire logic in4_event
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // A read request taken on this edge.
    sequence s_take(i, s);
        ce && od_req && !od_write && od_index == i && od_subindex == s;
    endsequence

    a_answer_next: assert property (ce && od_req |=> od_ack)
        else $error("request without answer");
    a_idle_quiet: assert property (!od_ack |-> !od_abort && od_data == 16'h0000)
        else $error("answer lines busy outside ack");
    a_bad_subidx: assert property (ce && od_req && ((od_index == 16'h3024 &&
        od_subindex > 8'h05) || (od_index == 16'h3030 && od_subindex > 8'h06))
        |=> od_abort && od_abort_code == 32'h0609_0011) else $error("bad sub-index kept");
    a_write_refused: assert property (ce && od_req && od_write |=> od_abort)
        else $error("write accepted");
    a_count_six: assert property (s_take(16'h3030, 8'h00) |=> od_data == 16'h0006)
        else $error("wrong entry count");
    a_goal_reserved: assert property (s_take(16'h3030, 8'h02)
        |=> od_data[2] && od_data[15:7] == 9'h000) else $error("state mask spare bits");
    a_raw_levels: assert property (s_take(16'h3030, 8'h04)
        |=> od_data == {12'h000, $past(dig_out)}) else $error("raw levels differ");
    a_drive_ok_out: assert property ($stable(drive_alarm) [*3]
        |-> dig_out[0] == (!drive_alarm ^ OUT_POLARITY[0])) else $error("output 1 wrong");
    a_brake_out: assert property ($stable(brake_engaged) [*3]
        |-> dig_out[3] == (brake_engaged ^ OUT_POLARITY[3])) else $error("output 4 wrong");
    a_event_single: assert property (in4_event |=> !in4_event)
        else $error("event longer than one cycle");
endmodule : dfm_top_sva

bind dfm_top dfm_top_sva #(.OUT_POLARITY(OUT_POLARITY)) u_sva (.ref_clk, .rst_b, .ce,
    .od_req, .od_write, .od_index, .od_subindex, .od_ack, .od_abort, .od_data,
    .od_abort_code, .drive_alarm, .brake_engaged, .dig_out, .in4_event);
`default_nettype wire

// ---- tb/dfm_master.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Bus master model issuing one-cycle object dictionary requests.
// ==========================================================================
module dfm_master (
    // Clock.
    input wire logic ref_clk,
    // Request side.
    output logic od_req = 1'b0,
    output logic od_write = 1'b0,
    output logic [15:0] od_index = 16'h0000,
    output logic [7:0] od_subindex = 8'h00,
    // Answer side.
    input wire logic od_ack,
    input wire logic [15:0] od_data,
    input wire logic [31:0] od_abort_code
);
    // One access; released qualifiers show inverted junk, never the old value.
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          output logic [15:0] dat, output logic [31:0] code);
        @(posedge ref_clk);
        #1;
        od_req = 1'b1;
        od_write = wr;
        od_index = idx;
        od_subindex = sub;
        @(posedge ref_clk);
        #1;
        od_req = 1'b0;
        od_write = ~wr;
        od_index = ~idx;
        od_subindex = ~sub;
        dat = (od_ack === 1'b1) ? od_data : 16'hxxxx;
        code = (od_ack === 1'b1) ? od_abort_code : 32'hxxxx_xxxx;
    endtask : access
endmodule : dfm_master
`default_nettype wire

// ---- tb/dfm_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Self-checking bench for the function map.
// ==========================================================================
module dfm_top_tb;
    logic ref_clk = 1'b0, rst_b = 1'b0, ce = 1'b1, din4_pin = 1'b0, drive_alarm = 1'b0;
    logic drive_warning = 1'b1, brake_engaged = 1'b0, drive_ready = 1'b1;
    logic full_turn_sense = 1'b0, od_req, od_write, od_ack, od_abort, in4_event;
    logic [15:0] od_index, od_data, rd, threshold_time_ms = 16'h0002;
    logic [7:0] od_subindex;
    logic [31:0] od_abort_code, rc, velocity = 32'h0, velocity_threshold = 32'h5;
    logic [3:0] dig_out;
    int num_errors = 0, n_tests = 0, k = 0;

    dfm_top #(.IN4_FUNCTION(4'hc), .IN4_POLARITY(1'b1), .OUT_POLARITY(16'h0008),
        .MS_CYCLES(4)) DUT (.ref_clk, .rst_b, .ce, .od_req, .od_write, .od_index,
        .od_subindex, .od_ack, .od_abort, .od_data, .od_abort_code, .drive_alarm,
        .drive_warning, .brake_engaged, .drive_ready, .full_turn_sense, .velocity,
        .velocity_threshold, .threshold_time_ms, .din4_pin, .dig_out, .in4_event);
    dfm_master M (.ref_clk, .od_req, .od_write, .od_index, .od_subindex, .od_ack,
        .od_data, .od_abort_code);

    // Clock and event counter.
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (in4_event === 1'b1) k++;

    // Compares one seen value against its expectation.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One access with expected data and abort code.
    task automatic rd_chk(logic wr, logic [15:0] i, logic [7:0] s, logic [15:0] d, logic [31:0] c);
        M.access(wr, i, s, rd, rc);
        check({16'h0, rd}, {16'h0, d});
        check(rc, c);
    endtask : rd_chk

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test;
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    // Watchdog sized well above the roughly one hundred cycles the tests need.
    initial begin
        #20000;
        num_errors++;
        finish_test();
    end

    // Main sequence.
    initial begin
        repeat (5) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        rd_chk(0, 16'h3024, 8'h00, 16'h0005, 0);
        rd_chk(0, 16'h3024, 8'h01, 16'h000c, 0);
        rd_chk(0, 16'h3024, 8'h03, 16'h0001, 0);
        rd_chk(0, 16'h3024, 8'h05, 16'h0000, 0);
        rd_chk(0, 16'h3024, 8'h06, 16'h0000, 32'h0609_0011);
        rd_chk(0, 16'h3030, 8'h00, 16'h0006, 0);
        rd_chk(0, 16'h3030, 8'h01, 16'h001b, 0);
        rd_chk(0, 16'h3030, 8'h03, 16'h0008, 0);
        rd_chk(0, 16'h3030, 8'h06, 16'h0000, 0);
        rd_chk(0, 16'h3030, 8'h07, 16'h0000, 32'h0609_0011);
        rd_chk(1, 16'h3024, 8'h01, 16'h0000, dfm_pkg::ABORT_READ_ONLY);
        rd_chk(1, 16'h3030, 8'h02, 16'h0000, dfm_pkg::ABORT_READ_ONLY);
        rd_chk(1, 16'h3024, 8'h09, 16'h0000, 32'h0609_0011);
        rd_chk(0, 16'h3025, 8'h00, 16'h0000, dfm_pkg::ABORT_NO_OBJECT);
        // Pin rises then falls; only the falling edge raises the event.
        din4_pin = 1'b1;
        repeat (8) @(posedge ref_clk);
        rd_chk(0, 16'h3024, 8'h02, 16'h0001, 0);
        din4_pin = 1'b0;
        repeat (10) @(posedge ref_clk);
        check(k, 1);
        rd_chk(0, 16'h3024, 8'h02, 16'h0000, 0);
        // Function states, raw levels and physical outputs.
        rd_chk(0, 16'h3030, 8'h02, 16'h006c, 0);
        check(dig_out, 4'hf);
        rd_chk(0, 16'h3030, 8'h04, 16'h000f, 0);
        // Motion needs speed strictly above threshold for the set time.
        velocity = 32'ha;
        rd_chk(0, 16'h3030, 8'h02, 16'h006c, 0);
        repeat (20) @(posedge ref_clk);
        rd_chk(0, 16'h3030, 8'h02, 16'h004c, 0);
        #1 velocity = 32'h5;
        repeat (3) @(posedge ref_clk);
        rd_chk(0, 16'h3030, 8'h02, 16'h006c, 0);
        // Alarm, warning, ready, brake and full-turn change the mask; all but full-turn change the outputs.
        drive_alarm = 1'b1;
        drive_ready = 1'b0;
        brake_engaged = 1'b1;
        drive_warning = 1'b0;
        full_turn_sense = 1'b1;
        repeat (4) @(posedge ref_clk);
        rd_chk(0, 16'h3030, 8'h02, 16'h0037, 0);
        check(dig_out, 4'h0);
        finish_test();
    end
endmodule : dfm_top_tb
`default_nettype wire
